// *** verilog/spx_host.sv ***
// spx_host.sv: SPI master controller with an AHB-Lite register slave.
// Assumes one SPI slave on each select line and one AHB-Lite master.
// Behaviour
// R1 - Eight-bit shift register at each end.
// R2 - Bits leave most significant first.
// R3 - Incoming bit enters the bottom, contents move up.
// R4 - Drive on one clock edge, sample on the other.
// R5 - One bit each way every clock.
// R6 - Eight clocks swap the two bytes.
// R7 - Master out feeds slave in, slave out feeds master.
// R8 - Only the master makes the serial clock.
// R9 - Both ends use the same idle polarity.
// R10 - More bytes: reload registers, exchange again.
// R11 - Transactions may run any number of clocks.
// R12 - Stop the clock, then release select.
// R13 - At most one select asserted at once.
// R14 - Every slave has its own select line.
// R15 - Unselected slave ignores bus, drives nothing.
// R16 - Unselected slave output is preferably tri-stated; the bench slave model drives miso always and the bench muxes it by oe instead.
// R17 - Port runs SPI or I2C, not both.
// R18 - Master buffer write starts an exchange; the code drops one made while write_collision_flag is still set.
// R19 - Full byte sets buffer full and port flag.
// R20 - Write during exchange dropped, collision flag set.
// R21 - Master rate chosen from fixed or programmable dividers.
// R22 - Slave select is active low.
// R23 - Reset or disable returns port to idle.
`timescale 1ns/1ps
`include "spx_map.svh"

module spx_host
#(
  parameter int SEL_N = 4,
  parameter int DIV_W = 8
)
(
  // Clock, reset and enable
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic [31:0]           hrdata,
  output logic                  hresp,
  // SPI link
  output logic                  sck,
  output logic                  mosi,
  input  wire logic             miso,
  output logic [SEL_N-1:0]      ss_n
);

  localparam int HALF_W = DIV_W + 2;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [31:0]      ctrl;
  logic [DIV_W-1:0] rate_divisor;
  logic [7:0]       transfer_buffer;
  logic [7:0]       tx_byte;
  logic             buffer_full_flag;
  logic             write_collision_flag;
  logic             port_interrupt_flag;
  logic             dp_wr;
  logic [7:0]       dp_addr;
  logic             start;
  logic             miso_meta;
  logic             miso_sync;
  logic [31:0]      stat_word;
  logic [31:0]      rd_word;
  wire              shift_busy;
  wire              shift_done;
  wire [7:0]        rx_byte;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [HALF_W-1:0] spx_half(input spx_pkg::spx_rate_t r,
                                                 input logic [DIV_W-1:0]  d);
    case (r)
      spx_pkg::SPX_RATE_DIV4:  spx_half = HALF_W'(`SPX_HALF_DIV4);
      spx_pkg::SPX_RATE_DIV16: spx_half = HALF_W'(`SPX_HALF_DIV16);
      spx_pkg::SPX_RATE_DIV64: spx_half = HALF_W'(`SPX_HALF_DIV64);
      default:                 spx_half = HALF_W'({d, 1'b0}) + HALF_W'(`SPX_HALF_DIV4);
    endcase
  endfunction : spx_half

  function automatic logic [SEL_N-1:0] spx_onehot(input logic [2:0] idx);
    spx_onehot = '0;
    for (int i = 0; i < SEL_N; i++)
    begin
      if (idx == 3'(i))
      begin
        spx_onehot[i] = 1'b1;
      end
    end
  endfunction : spx_onehot

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire       ap_valid = hsel && htrans[1] && hready;
  wire [7:0] ap_addr  = haddr[7:0];
  wire       rd_buf   = ap_valid && !hwrite && (ap_addr == `SPX_OFS_BUF);
  wire       wr_ctrl  = dp_wr && (dp_addr == `SPX_OFS_CTRL);
  wire       wr_stat  = dp_wr && (dp_addr == `SPX_OFS_STAT);
  wire       wr_buf   = dp_wr && (dp_addr == `SPX_OFS_BUF);
  wire       wr_div   = dp_wr && (dp_addr == `SPX_OFS_DIV);

  wire       enable   = ctrl[`SPX_CTRL_EN];
  wire       cpol     = ctrl[`SPX_CTRL_CPOL];
  wire       cpha     = ctrl[`SPX_CTRL_CPHA];
  wire       sel_on   = ctrl[`SPX_CTRL_SELON];
  wire [2:0] sel_idx  = ctrl[`SPX_CTRL_SEL+2:`SPX_CTRL_SEL];
  wire [1:0] rate_raw = ctrl[`SPX_CTRL_RATE+1:`SPX_CTRL_RATE];
  wire spx_pkg::spx_rate_t rate = spx_pkg::spx_rate_t'(rate_raw);

  // A start pulse still in flight counts as busy, so that a buffer write in
  // the very next data phase collides instead of overwriting the byte.
  wire busy_any = shift_busy || start;
  wire buf_ok   = wr_buf && enable && !busy_any && !write_collision_flag; // [R18]
  wire buf_col  = wr_buf && busy_any;                                     // [R20]
  wire clr_write_collision_flag = wr_stat && hwdata[`SPX_STAT_WRITE_COLLISION_FLAG];
  wire clr_done = wr_stat && hwdata[`SPX_STAT_DONE];

  wire [HALF_W-1:0] half_cnt = spx_half(rate, rate_divisor); // [R21]
  wire [SEL_N-1:0]  next_sel = (enable && sel_on) ? spx_onehot(sel_idx) : '0; // [R13] [R14]

  // Hardware sets win over software clears in the same cycle.
  wire next_full = shift_done || (buffer_full_flag && !rd_buf); // [R19]
  wire next_write_collision_flag = buf_col || (write_collision_flag && !clr_write_collision_flag);
  wire next_done = shift_done || (port_interrupt_flag && !clr_done);

  always_comb
  begin
    stat_word                 = '0;
    stat_word[`SPX_STAT_BUSY] = busy_any;
    stat_word[`SPX_STAT_FULL] = buffer_full_flag;
    stat_word[`SPX_STAT_WRITE_COLLISION_FLAG] = write_collision_flag;
    stat_word[`SPX_STAT_DONE] = port_interrupt_flag;
  end

  always_comb
  begin
    case (ap_addr)
      `SPX_OFS_CTRL: rd_word = ctrl;
      `SPX_OFS_STAT: rd_word = stat_word;
      `SPX_OFS_BUF:  rd_word = {24'h000000, transfer_buffer};
      `SPX_OFS_DIV:  rd_word = 32'(rate_divisor);
      default:       rd_word = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  // Read data is taken in the address phase, so a read that directly follows
  // a write to the same register returns the value before that write.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_wr     <= 1'b0;
      dp_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else if (ce)
    begin
      dp_wr     <= ap_valid && hwrite;
      dp_addr   <= ap_addr;
      hrdata    <= (ap_valid && !hwrite) ? rd_word : hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Registers and flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl                 <= `SPX_CTRL_RST;
      rate_divisor         <= DIV_W'(`SPX_DIV_RST);
      buffer_full_flag     <= 1'b0;
      write_collision_flag <= 1'b0;
      port_interrupt_flag  <= 1'b0;
    end
    else if (ce)
    begin
      ctrl                 <= wr_ctrl ? (hwdata & `SPX_CTRL_MASK) : ctrl;
      rate_divisor         <= wr_div ? hwdata[DIV_W-1:0] : rate_divisor;
      buffer_full_flag     <= next_full;
      write_collision_flag <= next_write_collision_flag;
      port_interrupt_flag  <= next_done;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start           <= 1'b0;
      tx_byte         <= 8'h00;
      transfer_buffer <= 8'h00;
    end
    else if (ce)
    begin
      start           <= buf_ok;                                           // [R10]
      tx_byte         <= buf_ok ? hwdata[7:0] : tx_byte;
      transfer_buffer <= shift_done ? rx_byte : transfer_buffer;           // [R6]
    end
  end

  // ----------------------------------------------------------------------
  // Select lines and input synchroniser
  // ----------------------------------------------------------------------
  // Selects only move between bytes, so a select held by software spans as
  // many bytes as it likes and is released only once the clock has stopped.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ss_n      <= '1;
      miso_meta <= 1'b0;
      miso_sync <= 1'b0;
    end
    else if (ce)
    begin
      ss_n      <= busy_any ? ss_n : ~next_sel;                            // [R11] [R12] [R22]
      miso_meta <= miso;                                                   // [R7]
      miso_sync <= miso_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------------
  spx_shifter #(
    .HALF_W   (HALF_W)
  ) u_shifter ( // [R17]
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .start    (start),
    .abort    (!enable), // [R23]
    .tx_byte  (tx_byte),
    .cpol     (cpol),
    .cpha     (cpha),
    .half_cnt (half_cnt),
    .miso     (miso_sync),
    .sck      (sck),
    .mosi     (mosi),
    .busy     (shift_busy),
    .done     (shift_done),
    .rx_byte  (rx_byte)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence spx_buf_accept;
    buf_ok;
  endsequence

  sequence spx_run_begins;
    ##1 start ##1 shift_busy;
  endsequence

  AST_START: assert property (@(posedge clk) disable iff (!rst_n || !ce) // [R18]
    spx_buf_accept |-> spx_run_begins)
    else $error("accepted buffer write did not start an exchange");

  AST_COLLIDE: assert property (@(posedge clk) disable iff (!rst_n || !ce) // [R20]
    buf_col |=> (write_collision_flag && $stable(tx_byte)))
    else $error("write during an exchange was not refused");

  AST_ONE_SEL: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    $onehot0(~ss_n))
    else $error("more than one select asserted");

  AST_SEL_HOLD: assert property (@(posedge clk) disable iff (!rst_n || !ce) // [R11]
    (busy_any && $past(busy_any)) |-> $stable(ss_n))
    else $error("select moved during an exchange");

  AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_n || !ce) // [R12]
    (|(ss_n & ~$past(ss_n))) |-> (!$past(shift_busy) && (sck == $past(cpol))))
    else $error("select released while the clock still ran");

  AST_RX_STORE: assert property (@(posedge clk) disable iff (!rst_n || !ce) // [R19]
    shift_done |=> (buffer_full_flag && port_interrupt_flag
                    && (transfer_buffer == $past(rx_byte))))
    else $error("received byte not stored with its flags");

  AST_FULL_WINS: assert property (@(posedge clk) disable iff (!rst_n || !ce) // [R19]
    (shift_done && rd_buf) |=> buffer_full_flag)
    else $error("new byte lost its full flag to a read");

  AST_SYNC: assert property (@(posedge clk) disable iff (!rst_n || !ce) // [R7]
    ($past(ce) && $past(rst_n)) |-> (miso_meta == $past(miso)))
    else $error("data input synchroniser slipped");

endmodule : spx_host

// *** pkg/spx_map.svh ***
// spx_map.svh: register offsets, field positions, reset values and counts.
// Assumes inclusion by bare name from the controller design files.
`ifndef SPX_MAP_SVH
`define SPX_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SPX_OFS_CTRL   8'h00
`define SPX_OFS_STAT   8'h04
`define SPX_OFS_BUF    8'h08
`define SPX_OFS_DIV    8'h0C

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SPX_CTRL_EN    0
`define SPX_CTRL_CPOL  1
`define SPX_CTRL_CPHA  2
`define SPX_CTRL_RATE  4
`define SPX_CTRL_SEL   8
`define SPX_CTRL_SELON 12
`define SPX_CTRL_MASK  32'h0000_1737
`define SPX_CTRL_RST   32'h0000_0000
`define SPX_STAT_BUSY  0
`define SPX_STAT_FULL  1
`define SPX_STAT_WRITE_COLLISION_FLAG  2
`define SPX_STAT_DONE  3
`define SPX_DIV_RST    8'h00

// ----------------------------------------------------------------------
// Half periods of the serial clock in system clocks, and serial clock edges per byte
// ----------------------------------------------------------------------
`define SPX_HALF_DIV4  10'h002
`define SPX_HALF_DIV16 10'h008
`define SPX_HALF_DIV64 10'h020
`define SPX_LAST_EDGE  5'h0F
`define SPX_EDGES      5'h10

`endif

// *** pkg/spx_pkg.sv ***
// spx_pkg.sv: types shared by the serial controller files.
// Assumes nothing of its surroundings.
package spx_pkg;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    SPX_ST_IDLE  = 3'b001,
    SPX_ST_SETUP = 3'b010,
    SPX_ST_SHIFT = 3'b100
  } spx_state_t;

  typedef enum logic [1:0]
  {
    SPX_RATE_DIV4    = 2'h0,
    SPX_RATE_DIV16   = 2'h1,
    SPX_RATE_DIV64   = 2'h2,
    SPX_RATE_DIVISOR = 2'h3
  } spx_rate_t;

endpackage : spx_pkg

// *** verilog/spx_shifter.sv ***
// spx_shifter.sv: byte shifter that makes the serial clock and exchanges a byte.
// Assumes a synchronised data input and a half period of at least two clocks.
`timescale 1ns/1ps
`include "spx_map.svh"

module spx_shifter
#(
  parameter int HALF_W = 10
)
(
  // Clock, reset and enable
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // Control
  input  wire logic              start,
  input  wire logic              abort,
  input  wire logic [7:0]        tx_byte,
  input  wire logic              cpol,
  input  wire logic              cpha,
  input  wire logic [HALF_W-1:0] half_cnt,
  // Serial pins
  input  wire logic              miso,
  output logic                   sck,
  output logic                   mosi,
  // Result
  output logic                   busy,
  output logic                   done,
  output logic [7:0]             rx_byte
);

  spx_pkg::spx_state_t state;
  spx_pkg::spx_state_t next_state;
  logic [HALF_W-1:0]   cnt;
  logic [4:0]          edge_n;
  logic [7:0]          byte_shifter;
  logic [4:0]          tog;

  wire hit        = (cnt == HALF_W'(1));
  wire run        = (state == spx_pkg::SPX_ST_SHIFT);
  wire idle       = (state == spx_pkg::SPX_ST_IDLE);
  wire last       = (edge_n == `SPX_LAST_EDGE);
  wire do_sample  = run && hit && (edge_n[0] == cpha);
  wire do_drive   = run && hit && (edge_n[0] != cpha);
  wire [7:0] next_shift = do_sample ? {byte_shifter[6:0], miso} : byte_shifter; // [R3]
  wire next_sck   = idle ? cpol : ((run && hit) ? ~sck : sck); // [R8]

  assign busy = !idle;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    case (state)
      spx_pkg::SPX_ST_IDLE:  next_state = start ? spx_pkg::SPX_ST_SETUP : state;
      spx_pkg::SPX_ST_SETUP: next_state = hit ? spx_pkg::SPX_ST_SHIFT : state;
      spx_pkg::SPX_ST_SHIFT: next_state = (hit && last) ? spx_pkg::SPX_ST_IDLE : state; // [R6]
      default:               next_state = spx_pkg::SPX_ST_IDLE;
    endcase
    if (abort)
    begin
      next_state = spx_pkg::SPX_ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state  <= spx_pkg::SPX_ST_IDLE;
      cnt    <= '0;
      edge_n <= '0;
    end
    else if (ce)
    begin
      state  <= next_state;
      cnt    <= (idle || hit) ? half_cnt : cnt - HALF_W'(1);
      edge_n <= idle ? 5'h00 : ((run && hit) ? edge_n + 5'h01 : edge_n);
    end
  end

  // ----------------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------------
  // A collision on the slave side cannot corrupt this register: it is only
  // loaded while idle, so the exchanged byte is always whole.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_shifter <= '0;
      sck          <= 1'b0;
      mosi         <= 1'b0;
      done         <= 1'b0;
      rx_byte      <= '0;
    end
    else if (ce)
    begin
      byte_shifter <= (idle && start) ? tx_byte : next_shift;              // [R1] [R10]
      sck          <= next_sck;                                            // [R5] [R9]
      if (idle && start && !cpha)
      begin
        mosi <= tx_byte[7];                                                // [R2]
      end
      else if (do_drive)
      begin
        mosi <= byte_shifter[7];                                           // [R4]
      end
      done    <= run && hit && last && !abort;
      rx_byte <= (run && hit && last) ? next_shift : rx_byte;              // [R6]
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tog <= '0;
    end
    else if (ce)
    begin
      tog <= (idle && start) ? 5'h00 : ((next_sck != sck && !idle) ? tog + 5'h01 : tog);
    end
  end

  AST_MSB_FIRST: assert property (@(posedge clk) disable iff (!rst_n || !ce) // [R2]
    (idle && start && !cpha && !abort) |=> (mosi == $past(tx_byte[7])))
    else $error("first bit out is not the top bit");

  AST_SHIFT_IN: assert property (@(posedge clk) disable iff (!rst_n || !ce) // [R3]
    do_sample |=> (byte_shifter == {$past(byte_shifter[6:0]), $past(miso)}))
    else $error("sampled bit did not enter the bottom of the shifter");

  AST_EDGE_COUNT: assert property (@(posedge clk) disable iff (!rst_n || !ce) // [R5]
    done |-> (tog == `SPX_EDGES))
    else $error("byte ended without sixteen serial clock edges");

  AST_SCK_IDLE: assert property (@(posedge clk) disable iff (!rst_n || !ce) // [R9]
    (idle && $past(idle)) |-> (sck == $past(cpol)))
    else $error("idle serial clock is not at the programmed polarity");

  AST_DRIVE_EDGE: assert property (@(posedge clk) disable iff (!rst_n || !ce) // [R4]
    ($past(run) && $changed(mosi)) |-> $past(do_drive))
    else $error("data out changed away from a drive edge");

endmodule : spx_shifter

// *** bench/spx_slave_model.sv ***
// spx_slave_model.sv: behavioural SPI slave that answers the controller.
// Assumes sck, mosi and its select come straight from the controller pins.
`timescale 1ns/1ps

module spx_slave_model
(
  // Serial pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  output logic            miso,
  output logic            oe,
  // Mode and data
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte,
  output int              nbytes
);
  logic [7:0] sr;
  logic [2:0] bitn;
  logic [7:0] idx;

  // The bench floats the shared line while no slave drives it.
  assign oe = !ss_n;

  initial
  begin
    {sr, bitn, idx, miso, rx_byte} = '0;
    nbytes = 0;
  end

  always @(negedge ss_n)
  begin
    sr   = tx_byte;
    bitn = 3'h0;
    idx  = 8'h00;
    miso = tx_byte[7];
  end

  // The mode bit picks which edge samples; the other edge drives.
  always @(sck)
  begin
    if (!ss_n && ((sck != cpol) ^ cpha))
    begin
      if (bitn == 3'h7)
      begin
        rx_byte = {sr[6:0], mosi};
        nbytes  = nbytes + 1;
        idx     = idx + 8'h01;
        sr      = tx_byte + idx;
      end
      else
      begin
        sr = {sr[6:0], mosi};
      end
      bitn = bitn + 3'h1;
    end
    else if (!ss_n)
    begin
      miso = sr[7];
    end
  end
endmodule : spx_slave_model

// *** bench/testbench.sv ***
// testbench.sv: self-checking bench for the SPI controller and two slaves.
// Assumes a 40 MHz clock and a zero-wait AHB-Lite register slave.
`timescale 1ns/1ps
`include "spx_map.svh"

module testbench;
  typedef struct
  {
    logic [1:0] rate;
    logic [7:0] div;
    logic       cpol;
    logic       cpha;
    logic [2:0] sel;
    logic [7:0] mtx;
    logic [7:0] stx;
  } spx_row_t;

  spx_row_t    rows [6] = '{'{2'h1, 8'h00, 1'b0, 1'b0, 3'h0, 8'hA5, 8'h3C},
                            '{2'h1, 8'h00, 1'b1, 1'b0, 3'h1, 8'hC3, 8'h81},
                            '{2'h2, 8'h00, 1'b0, 1'b1, 3'h0, 8'h01, 8'hFE},
                            '{2'h3, 8'h01, 1'b1, 1'b1, 3'h1, 8'h80, 8'h7F},
                            '{2'h3, 8'h03, 1'b0, 1'b1, 3'h0, 8'h5A, 8'h96},
                            '{2'h1, 8'h00, 1'b1, 1'b1, 3'h1, 8'hFF, 8'h00}};
  logic        clk, rst_n, ce, hsel, hwrite, hreadyout, hresp;
  logic        sck, mosi, miso, flt, sck_q, cpol, cpha, so0, so1, oe0, oe1;
  logic [1:0]  htrans;
  logic [3:0]  ss_n, ss_q;
  logic [7:0]  stx, rx0, rx1;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          nb0, nb1, hc, half, n, miscompares, num_checks;

  spx_host u_dut
  (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .sck(sck), .mosi(mosi), .miso(miso), .ss_n(ss_n)
  );
  spx_slave_model u_slv0 (.sck(sck), .mosi(mosi), .ss_n(ss_n[0]), .miso(so0), .oe(oe0),
    .cpol(cpol), .cpha(cpha), .tx_byte(stx), .rx_byte(rx0), .nbytes(nb0));
  spx_slave_model u_slv1 (.sck(sck), .mosi(mosi), .ss_n(ss_n[1]), .miso(so1), .oe(oe1),
    .cpol(cpol), .cpha(cpha), .tx_byte(stx), .rx_byte(rx1), .nbytes(nb1));

  assign miso = oe0 ? so0 : (oe1 ? so1 : flt);

  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------------
  always @(posedge clk)
  begin
    sck_q <= sck;
    ss_q  <= ss_n;
    flt   <= ~flt;
    hc    <= (sck !== sck_q) ? 1 : hc + 1;
    if (sck !== sck_q)
      half <= hc;
    if (rst_n && ss_n !== ss_q && (sck !== cpol || $countones(~ss_n) > 1))
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, {sck, ss_n}, {cpol, ss_q});
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wait_rdy;
    for (int k = 0; k < 50; k++)
    begin
      @(posedge clk);
      if (hreadyout === 1'b1)
        return;
    end
    miscompares++;
    tally_and_finish;
  endtask : wait_rdy

  // The master holds each phase until hready is seen high at an edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask : xfer

  task automatic wait_done;
    for (int k = 0; k < 1000; k++)
    begin
      xfer(1'b0, `SPX_OFS_STAT, 32'h0);
      if (rd[`SPX_STAT_DONE] === 1'b1)
        return;
    end
    miscompares++;
    tally_and_finish;
  endtask : wait_done

  function automatic logic [31:0] ctrl(input logic on, input spx_row_t r);
    return {19'h0, on, 1'b0, r.sel, 2'h0, r.rate, 1'b0, r.cpha, r.cpol, 1'b1};
  endfunction : ctrl

  task automatic run_row(input spx_row_t r);
    int no;
    no   = r.sel[0] ? nb0 : nb1;
    stx  = r.stx;
    cpol = r.cpol;
    cpha = r.cpha;
    xfer(1'b1, `SPX_OFS_DIV, {24'h0, r.div});
    xfer(1'b1, `SPX_OFS_CTRL, ctrl(1'b0, r));
    xfer(1'b1, `SPX_OFS_CTRL, ctrl(1'b1, r));
    xfer(1'b1, `SPX_OFS_BUF, {24'h0, r.mtx});
    chk({28'h0, ss_n}, {28'h0, ~(4'h1 << r.sel)});
    xfer(1'b0, `SPX_OFS_STAT, 32'h0);
    chk(rd & 32'h1, 32'h1);
    wait_done;
    chk(rd, 32'hA);
    chk(half, (r.rate == 2'h1) ? 8 : (r.rate == 2'h2) ? 32 : 2 * (r.div + 1));
    xfer(1'b0, `SPX_OFS_BUF, 32'h0);
    chk(rd, {24'h0, r.stx});
    chk({24'h0, r.sel[0] ? rx1 : rx0}, {24'h0, r.mtx});
    xfer(1'b0, `SPX_OFS_STAT, 32'h0);
    chk(rd & 32'h2, 32'h0);
    xfer(1'b1, `SPX_OFS_CTRL, ctrl(1'b0, r));
    xfer(1'b1, `SPX_OFS_STAT, 32'h8);
    chk(r.sel[0] ? nb0 : nb1, no);
    chk({28'h0, ss_n}, 32'hF);
    $display("test row done");
  endtask : run_row

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {clk, rst_n, hsel, hwrite, htrans, haddr, hwdata, cpol, cpha, stx, flt, sck_q} = '0;
    ce          = 1'b1;
    ss_q        = 4'hF;
    hc          = 0;
    half        = 0;
    miscompares = 0;
    num_checks  = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk({27'h0, sck, ss_n}, 32'hF);
    for (int a = 0; a <= 16; a += 4)
    begin
      xfer(1'b0, a[7:0], 32'h0);
      chk(rd, 32'h0);
    end
    chk({31'h0, hresp}, 32'h0);
    $display("test reset done");
    foreach (rows[i])
      run_row(rows[i]);
    // A write while busy must not disturb the byte in flight.
    stx  = 8'h3C;
    cpol = 1'b0;
    cpha = 1'b0;
    xfer(1'b1, `SPX_OFS_CTRL, ctrl(1'b1, rows[0]));
    n = nb0;
    xfer(1'b1, `SPX_OFS_BUF, 32'h11);
    xfer(1'b1, `SPX_OFS_BUF, 32'h22);
    xfer(1'b0, `SPX_OFS_STAT, 32'h0);
    chk(rd & 32'h5, 32'h5);
    wait_done;
    xfer(1'b0, `SPX_OFS_BUF, 32'h0);
    chk(rd, 32'h3C);
    chk({24'h0, rx0}, 32'h11);
    xfer(1'b1, `SPX_OFS_BUF, 32'h33);
    xfer(1'b0, `SPX_OFS_STAT, 32'h0);
    chk(rd & 32'h5, 32'h4);
    xfer(1'b1, `SPX_OFS_STAT, 32'hC);
    xfer(1'b1, `SPX_OFS_BUF, 32'h44);
    wait_done;
    xfer(1'b0, `SPX_OFS_BUF, 32'h0);
    chk(rd, 32'h3D);
    chk({24'h0, rx0}, 32'h44);
    chk(nb0 - n, 2);
    xfer(1'b1, `SPX_OFS_STAT, 32'h8);
    xfer(1'b1, `SPX_OFS_BUF, 32'h55);
    xfer(1'b1, `SPX_OFS_CTRL, ctrl(1'b1, rows[0]) & ~32'h1);
    xfer(1'b0, `SPX_OFS_STAT, 32'h0);
    chk(rd & 32'h9, 32'h0);
    chk({31'h0, sck}, 32'h0);
    xfer(1'b1, `SPX_OFS_CTRL, ctrl(1'b0, rows[0]));
    $display("test collision done");
    // A reset in the middle of a byte must leave the link idle and deselected.
    xfer(1'b1, `SPX_OFS_CTRL, ctrl(1'b1, rows[0]));
    xfer(1'b1, `SPX_OFS_BUF, 32'h66);
    repeat (40) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk({27'h0, sck, ss_n}, 32'hF);
    xfer(1'b0, `SPX_OFS_STAT, 32'h0);
    chk(rd, 32'h0);
    $display("test reset in run done");
    tally_and_finish;
  end
endmodule : testbench
